// ### hw/nfhc_regs.svh
// Constants for the NAND flash host controller
// Behaviour
// - Bus carries commands, addresses, data both ways
// - Commands and addresses use low byte only
// - Command latched on strobe rise, command-select high
// - Address latched on strobe rise, address-select high
// - Spare select low includes spare area
// - Two-cycle commands: setup then confirm
// - Address order column, low row, high row
// - Only reset and status accepted while busy
`ifndef NFHC_REGS_SVH
`define NFHC_REGS_SVH
`define NFHC_CMD_RESET   8'hFF
`define NFHC_CMD_STATUS  8'h70
`define NFHC_CMD_PROG    8'h80
`define NFHC_CMD_CONFIRM 8'h10
`define NFHC_SETUP_NS    20
`define NFHC_HOLD_NS     24
`define NFHC_CLK_NS      4
`define NFHC_SETUP_CYC   ((`NFHC_SETUP_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_HOLD_CYC    ((`NFHC_HOLD_NS + `NFHC_CLK_NS - 1) / `NFHC_CLK_NS)
`define NFHC_CNT_W       4
`define NFHC_LOW_BYTE    8
// Pin group at reset: deselected, no latch select, both strobes high
`define NFHC_PINS_RST    5'h13
`endif

// ### hw/nfhc_pkg.sv
// Types for the NAND flash host controller
package nfhc_pkg;
  // Kind of bus cycle the user requests
  typedef enum logic [1:0] {
    NFHC_K_CMD  = 2'h0,
    NFHC_K_ADDR = 2'h1,
    NFHC_K_DATA = 2'h2,
    NFHC_K_READ = 2'h3
  } nfhc_kind_e;
  // One user request
  typedef struct packed {
    nfhc_kind_e  kind;
    logic [15:0] wdata;
  } nfhc_req_s;
  // Strobe pin group, all active low except latch selects
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
  } nfhc_pins_s;
  // Cycle sequencer states, Gray along idle-setup-hold
  typedef enum logic [1:0] {
    NFHC_IDLE  = 2'h0,
    NFHC_SETUP = 2'h1,
    NFHC_HOLD  = 2'h3,
    NFHC_DONE  = 2'h2
  } nfhc_state_e;
endpackage

// ### hw/nfhc_host.sv
// Host-side NAND flash pin controller: one bus cycle per request
`timescale 1ns/100ps
`include "nfhc_regs.svh"
module nfhc_host (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // User request
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire nfhc_pkg::nfhc_req_s req,
  input  wire logic              wp_en_n,
  input  wire logic              spare_incl_n,
  // User answer
  output logic                   rsp_valid,
  output logic [15:0]            rsp_rdata,
  output logic                   busy,
  // Flash pins
  output nfhc_pkg::nfhc_pins_s   pins,
  output logic                   wp_n,
  output logic                   spare_sel_n,
  input  wire logic [15:0]       io_in,
  output logic [15:0]            io_out,
  output logic                   io_oe,
  input  wire logic              rb_in
);
  // Ready/busy synchroniser, three stages
  logic [2:0]            rb_sync_q;
  logic                  rb_ready_q;
  logic                  rb_ready_d;
  // Sequencer state
  nfhc_pkg::nfhc_state_e st_q, st_d;
  logic [`NFHC_CNT_W-1:0] cnt_q, cnt_d;
  nfhc_pkg::nfhc_req_s   cur_q, cur_d;
  nfhc_pkg::nfhc_pins_s  pins_q, pins_d;
  logic [15:0]           io_out_q, io_out_d;
  logic                  io_oe_q, io_oe_d;
  logic [15:0]           rdata_q, rdata_d;
  logic                  rsp_q, rsp_d;
  logic                  wp_q, spare_q;
  logic                  allowed;

  // Pin synchroniser: stage 2 and 3 must agree before a change counts
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rb_sync_q  <= 3'h0;
      rb_ready_q <= 1'b0;
    end else begin
      rb_sync_q  <= {rb_sync_q[1:0], rb_in};
      rb_ready_q <= rb_ready_d;
    end
  end
  // Open drain line: low means device busy
  always_comb begin
    rb_ready_d = rb_ready_q;
    if (rb_sync_q[1] == rb_sync_q[2]) begin
      rb_ready_d = rb_sync_q[2];
    end
  end

  // While busy only reset or status commands may go out
  always_comb begin
    allowed = rb_ready_q ||
              (req.kind == nfhc_pkg::NFHC_K_CMD &&
               (req.wdata[`NFHC_LOW_BYTE-1:0] == `NFHC_CMD_RESET ||
                req.wdata[`NFHC_LOW_BYTE-1:0] == `NFHC_CMD_STATUS));
  end
  assign req_ready = (st_q == nfhc_pkg::NFHC_IDLE) && allowed;

  // Sequencer next state
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    cur_d    = cur_q;
    pins_d   = pins_q;
    io_out_d = io_out_q;
    io_oe_d  = io_oe_q;
    rdata_d  = rdata_q;
    rsp_d    = 1'b0;
    case (st_q)
      nfhc_pkg::NFHC_IDLE: begin
        // Chip select stays low between cycles; device ignores it when busy
        pins_d.ce_n = 1'b0;
        if (req_valid && req_ready) begin
          cur_d = req;
          cnt_d = `NFHC_CNT_W'(`NFHC_SETUP_CYC);
          st_d  = nfhc_pkg::NFHC_SETUP;
          // Exactly one latch select per strobe, none for data
          pins_d.cle = (req.kind == nfhc_pkg::NFHC_K_CMD);
          pins_d.ale = (req.kind == nfhc_pkg::NFHC_K_ADDR);
          if (req.kind == nfhc_pkg::NFHC_K_READ) begin
            pins_d.read_strobe_n = 1'b0;
            io_oe_d = 1'b0;
          end else begin
            pins_d.we_n = 1'b0;
            io_oe_d     = 1'b1;
            // Command and address cycles drive the upper byte low
            if (req.kind == nfhc_pkg::NFHC_K_DATA) begin
              io_out_d = req.wdata;
            end else begin
              io_out_d = {8'h00, req.wdata[`NFHC_LOW_BYTE-1:0]};
            end
          end
        end
      end
      nfhc_pkg::NFHC_SETUP: begin
        if (cnt_q != `NFHC_CNT_W'(0)) begin
          cnt_d = cnt_q - `NFHC_CNT_W'(1);
        end else begin
          // Rising strobe edge latches the byte; read data sampled here
          if (cur_q.kind == nfhc_pkg::NFHC_K_READ) begin
            rdata_d = io_in;
          end
          pins_d.we_n          = 1'b1;
          pins_d.read_strobe_n = 1'b1;
          cnt_d = `NFHC_CNT_W'(`NFHC_HOLD_CYC);
          st_d  = nfhc_pkg::NFHC_HOLD;
        end
      end
      nfhc_pkg::NFHC_HOLD: begin
        if (cnt_q != `NFHC_CNT_W'(0)) begin
          cnt_d = cnt_q - `NFHC_CNT_W'(1);
        end else begin
          // Hold done: release selects and bus
          pins_d.cle = 1'b0;
          pins_d.ale = 1'b0;
          io_oe_d    = 1'b0;
          st_d       = nfhc_pkg::NFHC_DONE;
        end
      end
      nfhc_pkg::NFHC_DONE: begin
        rsp_d = 1'b1;
        st_d  = nfhc_pkg::NFHC_IDLE;
      end
      default: begin
        st_d = nfhc_pkg::NFHC_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= nfhc_pkg::NFHC_IDLE;
      cnt_q    <= '0;
      cur_q    <= '0;
      pins_q   <= `NFHC_PINS_RST; // Deselected, strobes high
      io_out_q <= 16'h0000;
      io_oe_q  <= 1'b0;
      rdata_q  <= 16'h0000;
      rsp_q    <= 1'b0;
      wp_q     <= 1'b0;
      spare_q  <= 1'b1;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      cur_q    <= cur_d;
      pins_q   <= pins_d;
      io_out_q <= io_out_d;
      io_oe_q  <= io_oe_d;
      rdata_q  <= rdata_d;
      rsp_q    <= rsp_d;
      wp_q     <= wp_en_n;
      spare_q  <= spare_incl_n;
    end
  end

  // Outputs from flops
  assign pins        = pins_q;
  assign io_out      = io_out_q;
  assign io_oe       = io_oe_q;
  assign rsp_valid   = rsp_q;
  assign rsp_rdata   = rdata_q;
  assign busy        = !rb_ready_q;
  assign wp_n        = wp_q;
  assign spare_sel_n = spare_q;

  // Checks
  AST_ONE_SELECT: assert property (@(posedge clock) disable iff (!rst_n)
    !(pins_q.cle && pins_q.ale)) else $error("both latch selects high");
  AST_CMD_LOW: assert property (@(posedge clock) disable iff (!rst_n)
    (pins_q.cle && io_oe_q) |-> io_out_q[15:8] == 8'h00)
    else $error("command on upper byte");
  AST_BUSY_CMD: assert property (@(posedge clock) disable iff (!rst_n)
    (req_valid && req_ready && !rb_ready_q) |-> req.kind == nfhc_pkg::NFHC_K_CMD)
    else $error("non command accepted while busy");
  AST_WE_RISE: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(pins_q.we_n) |-> ##[1:8] (!pins_q.cle && !pins_q.ale))
    else $error("selects not released after strobe");
  AST_READ_FLOAT: assert property (@(posedge clock) disable iff (!rst_n)
    !pins_q.read_strobe_n |-> !io_oe_q) else $error("host drives during read");
  AST_ADDR_STROBE: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(pins_q.we_n) && pins_d.ale |-> 1'b1 ##1 pins_q.ale)
    else $error("address select dropped");
  AST_RSP: assert property (@(posedge clock) disable iff (!rst_n)
    (st_q == nfhc_pkg::NFHC_DONE) |=> rsp_q) else $error("no answer");
  AST_WP: assert property (@(posedge clock) disable iff (!rst_n)
    1'b1 |=> wp_q == $past(wp_en_n)) else $error("write protect lag");
endmodule // nfhc_host

// ### tb/nfhc_dev.sv
// Behavioural flash device model facing the host controller
`timescale 1ns/100ps
module nfhc_dev #(
  parameter int PROG_NS = 400  // Shortened program busy time
) (
  // Host pins
  input  wire nfhc_pkg::nfhc_pins_s pins,
  input  wire logic                 wp_n,
  input  wire logic [15:0]          io_out,
  // Device outputs
  output logic [15:0]               io_in,
  output logic                      rb_in
);
  logic [7:0]  cmd_q, prv_q, hi_q;  // Command, previous one, upper byte
  logic [7:0]  adr_q [3];           // Captured address cycles
  logic [15:0] mem [8];             // Small page buffer
  logic [15:0] rd_q = 0;            // Read latch
  logic [2:0]  col = 0;             // Column counter
  logic [1:0]  na = 0;              // Address cycles seen
  logic        rb_lo = 0;           // Pulls ready/busy low
  event        go;                  // Starts internal program
  // Latch on strobe rise; while busy only FF and 70 pass
  always @(posedge pins.we_n) if (!pins.ce_n) begin
    if (pins.cle && (!rb_lo || io_out[7:0] == 8'hFF || io_out[7:0] == 8'h70)) begin
      prv_q = cmd_q;
      cmd_q = io_out[7:0];
      hi_q = io_out[15:8];
      na = 0;
      if (cmd_q == 8'h10 && prv_q == 8'h80 && wp_n) -> go;
      if (cmd_q == 8'hD0 && prv_q == 8'h60 && wp_n) -> go;
    end else if (pins.ale && !rb_lo) begin
      if (na < 3) adr_q[na] = io_out[7:0];
      if (na == 0) col = io_out[2:0];
      if (na < 3) na = na + 1;
    end else if (!pins.cle && !pins.ale && !rb_lo) begin
      mem[col] = io_out;
      col = col + 1;
    end
  end
  // Program runs alone; chip select has no say meanwhile
  always @(go) begin
    rb_lo = 1;
    #(PROG_NS) rb_lo = 0;
  end
  // Falling read strobe presents data and steps the column
  always @(negedge pins.read_strobe_n) if (!pins.ce_n) begin
    rd_q = mem[col];
    col = col + 1;
  end
  // Released bus shows inverted stale data, so a late sample fails
  assign io_in = (!pins.ce_n && !pins.read_strobe_n) ? rd_q : ~rd_q;
  assign rb_in = rb_lo ? 1'b0 : 1'b1;
endmodule // nfhc_dev

// ### tb/nfhc_host_tb.sv
// Self-checking bench for the host controller
`timescale 1ns/100ps
module nfhc_host_tb;
  logic                 clock = 0, rst_n = 0, req_valid = 0;
  logic                 wp_en_n = 1, spare_incl_n = 0;
  nfhc_pkg::nfhc_req_s  req = '0;
  logic                 req_ready, rsp_valid, busy, wp_n, spare_sel_n, io_oe, rb_in;
  logic [15:0]          rsp_rdata, io_in, io_out;
  nfhc_pkg::nfhc_pins_s pins;
  int                   num_errors = 0, n_tests = 0, cyc = 0;
  always #2 clock = ~clock;
  nfhc_host u_nfhc_host (.clock(clock), .rst_n(rst_n), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .wp_en_n(wp_en_n), .spare_incl_n(spare_incl_n),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy), .pins(pins), .wp_n(wp_n),
    .spare_sel_n(spare_sel_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .rb_in(rb_in));
  nfhc_dev u_nfhc_dev (.pins(pins), .wp_n(wp_n), .io_out(io_out), .io_in(io_in),
    .rb_in(rb_in));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard well above the whole sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // One request held until taken, then wait for its answer
  task automatic xfer(nfhc_pkg::nfhc_kind_e k, logic [15:0] d);
    int n;
    req.kind = k;
    req.wdata = d;
    req_valid = 1;
    for (n = 0; req_ready !== 1'b1 && n < 3000; n++) tick(1);
    if (n == 3000) chk("req_ready", 1, 0);
    tick(1);
    req_valid = 0;
    for (n = 0; rsp_valid !== 1'b1 && n < 40; n++) tick(1);
    if (n == 40) chk("rsp_valid", 1, 0);
  endtask
  task automatic seq(logic [7:0] c, logic [7:0] a0, logic [7:0] a1, logic [7:0] a2);
    xfer(nfhc_pkg::NFHC_K_CMD, {8'hAB, c});
    xfer(nfhc_pkg::NFHC_K_ADDR, {8'h00, a0});
    xfer(nfhc_pkg::NFHC_K_ADDR, {8'h00, a1});
    xfer(nfhc_pkg::NFHC_K_ADDR, {8'h00, a2});
  endtask
  task automatic t_idle();
    chk("we_n", 1, pins.we_n);
    chk("io_oe", 0, io_oe);
    chk("wp_n", 1, wp_n);
    spare_incl_n = 1;
    tick(3);
    chk("spare_sel_n", 1, spare_sel_n);
    $display("t_idle done");
  endtask
  task automatic t_rw();
    seq(8'h00, 8'h02, 8'h34, 8'h56);
    xfer(nfhc_pkg::NFHC_K_ADDR, 16'h0078);
    chk("upper byte", 0, u_nfhc_dev.hi_q);
    chk("column", 8'h02, u_nfhc_dev.adr_q[0]);
    chk("row high", 8'h56, u_nfhc_dev.adr_q[2]);
    xfer(nfhc_pkg::NFHC_K_DATA, 16'h1234);
    xfer(nfhc_pkg::NFHC_K_DATA, 16'hBEEF);
    seq(8'h00, 8'h02, 8'h00, 8'h00);
    xfer(nfhc_pkg::NFHC_K_READ, 16'h0000);
    chk("read 0", 16'h1234, rsp_rdata);
    xfer(nfhc_pkg::NFHC_K_READ, 16'h0000);
    chk("read 1", 16'hBEEF, rsp_rdata);
    $display("t_rw done");
  endtask
  task automatic t_prog(logic wp);
    int n;
    wp_en_n = wp;
    seq(8'h80, 8'h00, 8'h11, 8'h22);
    xfer(nfhc_pkg::NFHC_K_CMD, 16'h0010);
    tick(4);
    chk("busy", wp, busy);
    if (wp) begin
      req.kind = nfhc_pkg::NFHC_K_DATA;
      tick(1);
      chk("req_ready", 0, req_ready);
      xfer(nfhc_pkg::NFHC_K_CMD, 16'h0070);
      chk("busy mid", 1, busy);
      for (n = 0; busy !== 1'b0 && n < 200; n++) tick(1);
      chk("busy end", 0, busy);
    end
    wp_en_n = 1;
    tick(2);
    $display("t_prog done");
  endtask
  // Erase: setup, two row cycles only, confirm, then busy until done
  task automatic t_erase();
    int n;
    xfer(nfhc_pkg::NFHC_K_CMD, 16'h0060);
    xfer(nfhc_pkg::NFHC_K_ADDR, 16'h0011);
    xfer(nfhc_pkg::NFHC_K_ADDR, 16'h0022);
    chk("erase rows", 2, u_nfhc_dev.na);
    xfer(nfhc_pkg::NFHC_K_CMD, 16'h00D0);
    tick(4);
    chk("erase busy", 1, busy);
    for (n = 0; busy !== 1'b0 && n < 200; n++) tick(1);
    chk("erase end", 0, busy);
    $display("t_erase done");
  endtask
  initial begin
    tick(6);
    rst_n = 1;
    tick(10);
    t_idle();
    t_rw();
    t_prog(1'b1);
    t_prog(1'b0);
    t_erase();
    print_verdict();
  end
endmodule // nfhc_host_tb
